//--- dv/pbmc_mgmt_model.sv
// Purpose: Management controller model that issues register accesses.
// Assumes: One strobe cycle per access, launched 1 ns after clk rises.
// Notes: Address and data are inverted once released, never left stale.
`timescale 1ns/10ps
module pbmc_mgmt_model (
    input wire logic clk,        // Clock
    output logic wr_en,          // Write strobe
    output logic rd_en,          // Read strobe
    output logic [4:0] reg_addr, // Register address
    output logic [15:0] wr_data  // Write data
);
    // Idle values at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_addr = 5'h1f;
        wr_data = 16'hffff;
    end

    // One access: strobe held over exactly one taking edge
    task automatic access(input logic w, input logic [4:0] a,
                          input logic [15:0] d);
        @(posedge clk);
        #1;
        wr_en = w;
        rd_en = ~w;
        reg_addr = a;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_addr = ~a;
        wr_data = ~d;
    endtask
endmodule

//--- dv/tb.sv
// Purpose: Self-checking bench for the basic mode control register.
// Assumes: Dead time shortened to 20 cycles; straps held before use.
// Notes: Reads queue their expected word; a monitor pops and compares.
`timescale 1ns/10ps
module tb;
    import pbmc_pkg::*;
    localparam int DEAD = 20; // Short dead time keeps the run brief
    logic clk, nrst, wr_en, rd_en, rd_valid, an_started;
    logic s_speed, s_duplex, s_an, s_fiber, core_reset, loopback_en;
    logic speed_100, full_duplex, an_enable, an_restart, power_down;
    logic isolate, rx_dead;
    logic [4:0] reg_addr;
    logic [15:0] wr_data, rd_data, d;
    logic [15:0] exp_q[$]; // Expected read words, oldest first
    int failures = 0;
    int num_checks = 0;
    int restarts = 0; // Restart pulses seen
    int dead_cyc = 0; // Cycles with receive data invalid
    logic [31:0] seed = 32'd8147;

    pbmc_ctrl #(.DEAD_CYCLES(DEAD)) i_dut (.clk(clk), .nrst(nrst),
        .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
        .wr_data(wr_data), .strap_speed(s_speed), .strap_duplex(s_duplex),
        .strap_an_en(s_an), .fiber_mode_enable(s_fiber),
        .an_started(an_started), .rd_data(rd_data), .rd_valid(rd_valid),
        .core_reset(core_reset), .loopback_en(loopback_en),
        .speed_100(speed_100), .full_duplex(full_duplex),
        .an_enable(an_enable), .an_restart(an_restart),
        .power_down(power_down), .isolate(isolate), .rx_dead(rx_dead));
    pbmc_mgmt_model i_mgmt (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
        .reg_addr(reg_addr), .wr_data(wr_data));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Queue the expected word, then issue the read
    task automatic rd(input logic [15:0] exp);
        exp_q.push_back(exp);
        i_mgmt.access(1'b0, BMC_ADDR, 16'h0000);
    endtask

    task automatic wr(input logic [15:0] v);
        i_mgmt.access(1'b1, BMC_ADDR, v);
        @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Monitor: pairs each read answer with the oldest expectation;
    // looks at the falling edge, where the outputs have settled
    always @(negedge clk) begin
        if (an_restart === 1'b1) restarts++;
        if (rx_dead === 1'b1) dead_cyc++;
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(16'hdead, 16'h0000);
            else chk(rd_data, exp_q.pop_front());
        end
    end

    // Watchdog far beyond the roughly 135 cycles the test takes
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        an_started = 1'b0;
        {s_speed, s_duplex, s_an, s_fiber} = 4'b1110;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rd(16'h3100);
        chk({15'h0, an_enable}, 16'h0001);
        // Forced speed, duplex, power down and isolate, random bits
        for (int i = 0; i < 4; i++) begin
            d = 16'(xs());
            wr(d & 16'h2dff);
            chk({12'h000, speed_100, full_duplex, power_down, isolate},
                {12'h000, d[13], d[8], d[11], d[10]});
            rd(d & 16'h2d80);
        end
        wr(16'h0200);
        rd(16'h0000);
        chk(restarts[15:0], 16'h0000);
        wr(16'h1200);
        chk(restarts[15:0], 16'h0001);
        rd(16'h1200);
        // Clearing the bit while pending sends no new restart
        wr(16'h1000);
        chk(restarts[15:0], 16'h0001);
        rd(16'h1200);
        an_started = 1'b1;
        @(posedge clk);
        #1;
        an_started = 1'b0;
        rd(16'h1000);
        // Unmapped address must leave the register alone
        i_mgmt.access(1'b1, 5'h01 | 5'(xs()), 16'h4000);
        rd(16'h1000);
        wr(16'h4000);
        repeat (DEAD + 6) @(posedge clk);
        #1;
        chk({loopback_en, 15'(dead_cyc)}, 16'h8000 | 16'(DEAD));
        wr(16'h0000);
        chk({15'h0, loopback_en}, 16'h0000);
        {s_speed, s_duplex, s_an, s_fiber} = 4'b0111;
        repeat (6) @(posedge clk);
        wr(16'h8000);
        chk({15'h0, core_reset}, 16'h0001);
        wr(16'h4000);
        repeat (SWRST_CYC + 4) @(posedge clk);
        #1;
        chk({14'h0000, core_reset, loopback_en}, 16'h0000);
        rd(16'h0100);
        rd(16'h0100);
        repeat (4) @(posedge clk);
        chk(16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule

//--- verilog/pbmc_ctrl.sv
// Purpose: Basic mode control register with its control outputs.
// Assumes: A management frame engine supplies decoded accesses.
// Notes: Strap pins are sampled after reset release and on soft reset.
`timescale 1ns/10ps
// How it works
// - Bit 15 starts reset, self-clears when done
// - Soft reset reloads straps like hard reset
// - Loopback bit routes transmit to receive
// - Loopback enable gives receive dead period
// - Speed bit picks 100 or 10 Mb/s
// - Speed and duplex outputs follow their bits even with negotiation enabled
// - Negotiation enable reset value from strap
// - Fiber mode clears negotiation enable at strap load; writes can still set it
// - Power down keeps register access alive
// - Isolate disconnects MAC, management still works
// - Restart only acts while negotiation enabled
// - Restart reads one until negotiation starts
// - Clearing restart never disturbs running negotiation
// - Duplex bit picks full or half
module pbmc_ctrl
    import pbmc_pkg::*;
#(
    parameter int DEAD_CYCLES = DEAD_CYC,  // Loopback dead time in cycles
    parameter int SWRST_CYCLES = SWRST_CYC // Software reset length
) (
    input wire logic clk,              // 50 MHz clock
    input wire logic nrst,             // Synchronous reset, low
    input wire logic wr_en,            // Management write, one pulse
    input wire logic rd_en,            // Management read, one pulse
    input wire logic [4:0] reg_addr,   // Management register address
    input wire logic [15:0] wr_data,   // Write data
    input wire logic strap_speed,      // Speed strap pin
    input wire logic strap_duplex,     // Duplex strap pin
    input wire logic strap_an_en,      // Negotiation enable strap pin
    input wire logic fiber_mode_enable,// Fiber mode pin
    input wire logic an_started,       // Negotiation engine has begun
    output logic [15:0] rd_data,       // Read data, held
    output logic rd_valid,             // Read data valid pulse
    output logic core_reset,           // Datapath soft reset level
    output logic loopback_en,          // Transmit to receive loopback
    output logic speed_100,            // Effective forced speed
    output logic full_duplex,          // Effective forced duplex
    output logic an_enable,            // Negotiation enabled
    output logic an_restart,           // Negotiation restart pulse
    output logic power_down,           // Transceiver power down
    output logic isolate,              // MAC interface isolated
    output logic rx_dead               // Receive data not yet valid
);
    logic [3:0] strap_lv;             // Synchronised straps
    logic [15:0] reg_q, reg_d;        // Register image
    pbmc_state_e st_q, st_d;          // Sequencer state
    logic [15:0] cnt_q, cnt_d;        // Duration counter
    logic ld_q, ld_d;                 // Strap load pending after reset
    logic rst_seen_q, rst_seen_d;     // Restart forwarded, awaiting start
    logic [15:0] rdd_q, rdd_d;        // Read data register
    logic rdv_q, rdv_d;               // Read valid register
    logic arq_q, arq_d;               // Restart pulse register
    logic dead_q, dead_d;             // Receive dead flag register
    logic wr_hit, rd_hit;             // Address-decoded strobes

    pbmc_strap_sync #(.W(4)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin({fiber_mode_enable, strap_an_en, strap_duplex, strap_speed}),
        .level(strap_lv)
    );

    // Strap image of the whole register
    function automatic logic [15:0] strap_img(input logic [3:0] s);
        logic [15:0] v;
        v = BMC_RST;
        v[SPEED_BIT] = s[0];
        v[DUPLEX_BIT] = s[1];
        v[ANEN_BIT] = s[2] & ~s[3];
        return v;
    endfunction

    assign wr_hit = wr_en && (reg_addr == BMC_ADDR);
    assign rd_hit = rd_en && (reg_addr == BMC_ADDR);

    // Register, sequencer and self-clear next state
    always_comb begin
        reg_d = reg_q;
        st_d = st_q;
        cnt_d = cnt_q;
        ld_d = ld_q & (st_q == PBMC_SWRST);
        rst_seen_d = rst_seen_q;
        arq_d = 1'b0;
        rdv_d = rd_hit;
        rdd_d = rd_hit ? reg_q : rdd_q;
        // Straps settle through the sync chain before loading
        if (ld_q) begin
            reg_d = strap_img(strap_lv);
        end
        // Writes land in idle and in dead time alike; a running soft
        // reset drops them so that its re-strap is not undone
        if (wr_hit && st_q != PBMC_SWRST) begin
            // Write applied when the frame completes
            reg_d[15:7] = wr_data[15:7];
            reg_d[6:0] = 7'h00;
            // Restart only with negotiation enabled
            if (wr_data[RSTAN_BIT] && wr_data[ANEN_BIT]) begin
                arq_d = 1'b1;
                rst_seen_d = 1'b1;
            end else begin
                // Clearing bit 9 leaves the engine untouched
                reg_d[RSTAN_BIT] = rst_seen_q & reg_q[RSTAN_BIT];
            end
        end
        unique case (st_q)
            PBMC_IDLE: begin
                if (wr_hit) begin
                    if (wr_data[SWRST_BIT]) begin
                        st_d = PBMC_SWRST;
                        cnt_d = 16'(SWRST_CYCLES - 1);
                    end else if (wr_data[LOOP_BIT] && !reg_q[LOOP_BIT]) begin
                        st_d = PBMC_DEAD;
                        cnt_d = 16'(DEAD_CYCLES - 1);
                    end
                end
            end
            PBMC_SWRST: begin
                // Writes are dropped while the reset runs
                if (cnt_q == 16'h0000) begin
                    reg_d = strap_img(strap_lv);
                    rst_seen_d = 1'b0;
                    st_d = PBMC_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            PBMC_DEAD: begin
                // A soft reset cuts the dead time short
                if (wr_hit && wr_data[SWRST_BIT]) begin
                    st_d = PBMC_SWRST;
                    cnt_d = 16'(SWRST_CYCLES - 1);
                end else if (cnt_q == 16'h0000) begin
                    st_d = PBMC_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: st_d = PBMC_IDLE;
        endcase
        // Self-clear once the engine reports a start; a fresh restart
        // written in the same cycle wins and stays pending
        if (rst_seen_q && an_started && st_q != PBMC_SWRST && !arq_d) begin
            reg_d[RSTAN_BIT] = 1'b0;
            rst_seen_d = 1'b0;
        end
        if (st_d == PBMC_SWRST) begin
            reg_d[SWRST_BIT] = 1'b1;
        end
        // Registered so the dead flag leaves straight from a flop
        dead_d = (st_d == PBMC_DEAD);
    end

    // Register everything; reset defers strap load one cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_q <= BMC_RST;
            st_q <= PBMC_IDLE;
            cnt_q <= 16'h0000;
            ld_q <= 1'b1;
            rst_seen_q <= 1'b0;
            rdd_q <= 16'h0000;
            rdv_q <= 1'b0;
            arq_q <= 1'b0;
            dead_q <= 1'b0;
        end else begin
            reg_q <= reg_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            ld_q <= ld_d;
            rst_seen_q <= rst_seen_d;
            rdd_q <= rdd_d;
            rdv_q <= rdv_d;
            arq_q <= arq_d;
            dead_q <= dead_d;
        end
    end

    // Outputs straight from flops
    assign rd_data = rdd_q;
    assign rd_valid = rdv_q;
    assign core_reset = reg_q[SWRST_BIT];
    assign loopback_en = reg_q[LOOP_BIT];
    assign speed_100 = reg_q[SPEED_BIT];
    assign full_duplex = reg_q[DUPLEX_BIT];
    assign an_enable = reg_q[ANEN_BIT];
    assign an_restart = arq_q;
    assign power_down = reg_q[PDOWN_BIT];
    assign isolate = reg_q[ISO_BIT];
    assign rx_dead = dead_q;

    // Checks
    property p_swrst_sets;
        @(posedge clk) disable iff (!nrst)
        (st_q == PBMC_IDLE && wr_hit && wr_data[SWRST_BIT]) |=> core_reset;
    endproperty
    a_swrst_sets: assert property (p_swrst_sets)
        else $error("soft reset bit did not set");
    property p_restart_gated;
        @(posedge clk) disable iff (!nrst)
        (wr_hit && !wr_data[ANEN_BIT]) |=> !an_restart;
    endproperty
    a_restart_gated: assert property (p_restart_gated)
        else $error("restart fired with negotiation off");
    property p_loop_dead;
        @(posedge clk) disable iff (!nrst)
        (st_q == PBMC_IDLE && wr_hit && !wr_data[SWRST_BIT]
         && wr_data[LOOP_BIT] && !loopback_en) |=> rx_dead && loopback_en;
    endproperty
    a_loop_dead: assert property (p_loop_dead)
        else $error("loopback dead period missing");
    property p_rsv_zero;
        @(posedge clk) disable iff (!nrst) reg_q[6:0] == 7'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bits not zero");
    property p_swrst_done;
        @(posedge clk) disable iff (!nrst)
        (st_q == PBMC_SWRST && cnt_q == 16'h0000) |=>
        !core_reset && an_enable == ($past(strap_lv[2]) & ~$past(strap_lv[3]));
    endproperty
    a_swrst_done: assert property (p_swrst_done)
        else $error("soft reset did not re-strap");
    property p_fiber;
        @(posedge clk) disable iff (!nrst)
        (ld_q && strap_lv[3]) |=> !an_enable;
    endproperty
    a_fiber: assert property (p_fiber)
        else $error("fiber mode left negotiation on");
    property p_rst_clear;
        @(posedge clk) disable iff (!nrst)
        (rst_seen_q && an_started && st_q != PBMC_SWRST
         && !(wr_hit && wr_data[RSTAN_BIT] && wr_data[ANEN_BIT]))
        |=> !reg_q[RSTAN_BIT];
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("restart bit did not self-clear");
    property p_pd_read;
        @(posedge clk) disable iff (!nrst)
        (rd_hit && power_down) |=> rd_valid && rd_data[PDOWN_BIT];
    endproperty
    a_pd_read: assert property (p_pd_read)
        else $error("read failed in power down");
    c_swrst: cover property (@(posedge clk) st_q == PBMC_SWRST);
    c_dead: cover property (@(posedge clk) st_q == PBMC_DEAD);
    c_restart: cover property (@(posedge clk) an_restart);
endmodule

//--- verilog/pbmc_pkg.sv
// Purpose: Constants for the basic mode control register block.
// Assumes: 16-bit register at management address zero.
// Notes: Field positions, reset values and timing counts live here.
package pbmc_pkg;
    localparam logic [4:0] BMC_ADDR = 5'h00;     // Register address
    localparam int SWRST_BIT = 15;               // Software reset
    localparam int LOOP_BIT = 14;                // Loopback
    localparam int SPEED_BIT = 13;               // Speed select
    localparam int ANEN_BIT = 12;                // Auto-negotiation enable
    localparam int PDOWN_BIT = 11;               // Power down
    localparam int ISO_BIT = 10;                 // Isolate
    localparam int RSTAN_BIT = 9;                // Restart negotiation
    localparam int DUPLEX_BIT = 8;               // Duplex mode
    localparam int COLTEST_BIT = 7;              // Collision test
    localparam logic [15:0] BMC_RST = 16'h0000;  // Non-strapped bits at reset
    localparam int CLK_MHZ = 50;                 // Clock rate
    localparam int DEAD_US = 500;                // Loopback dead time, us
    localparam int DEAD_CYC = DEAD_US * CLK_MHZ; // Dead time in cycles
    localparam int SWRST_CYC = 16;               // Software reset duration
    typedef enum logic [1:0] {
        PBMC_IDLE = 2'b00,
        PBMC_SWRST = 2'b01,
        PBMC_DEAD = 2'b10
    } pbmc_state_e;
endpackage

//--- verilog/pbmc_strap_sync.sv
// Purpose: Three-flop synchroniser for the strap and fiber pins.
// Assumes: Pins are asynchronous to clk.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/10ps
module pbmc_strap_sync #(
    parameter int W = 4 // Number of pins
) (
    input wire logic clk,          // Clock
    input wire logic nrst,         // Synchronous reset, low
    input wire logic [W-1:0] pin,  // Raw pins
    output logic [W-1:0] level     // Filtered level
);
    logic [W-1:0] s1_q, s2_q, s3_q, lv_q; // Sync stages and held level
    logic [W-1:0] lv_d;                    // Next held level

    // Update only where the last two stages agree; while reset holds,
    // follow the third stage so settled straps are ready on release
    always_comb begin
        lv_d = lv_q;
        for (int i = 0; i < W; i++) begin
            if (!nrst || (s2_q[i] == s3_q[i])) begin
                lv_d[i] = s3_q[i];
            end
        end
    end

    // Stages keep shifting through reset; clearing them would hide the
    // strap levels from the load that follows release
    always_ff @(posedge clk) begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        lv_q <= lv_d;
    end

    assign level = lv_q;
endmodule
